// ==== rtl/wg_params.svh ====
`ifndef WG_PARAMS_SVH
`define WG_PARAMS_SVH

// ==========================================================
// Clock and timebase
`define WG_CLK_HZ 250000000
`define WG_OSC_HZ 10240
`define WG_OSC_DIV (`WG_CLK_HZ / `WG_OSC_HZ)

// ==========================================================
// Times in milliseconds, internal oscillator mode
`define WG_T_WD_LONG_MS 1600
`define WG_T_WD_SHORT_MS 100
`define WG_T_RST_STD_MS 50
`define WG_T_RST_LONG_MS 200
`define WG_MS_TO_TICKS(ms) (((ms) * `WG_OSC_HZ) / 1000)

// ==========================================================
// Counts in external clock periods
`define WG_EXT_NORMAL 1024
`define WG_EXT_LONG 4096
`define WG_EXT_RST_STD 512
`define WG_EXT_RST_LONG 2048

// ==========================================================
// Register offsets, byte addresses
`define WG_REG_STATE 8'h00
`define WG_REG_IRQ_STATUS 8'h04
`define WG_REG_IRQ_MASK 8'h08

// ==========================================================
// State register fields
`define WG_ST_RESET_N_BIT 0
`define WG_ST_EXPIRED_N_BIT 1
`define WG_ST_SUPPLY_OK_BIT 2
`define WG_ST_BACKUP_OK_BIT 3
`define WG_ST_LONG_TO_BIT 4
`define WG_ST_EXT_MODE_BIT 5
`define WG_ST_KICK_FLOAT_BIT 6

// ==========================================================
// Interrupt status and mask fields
`define WG_IRQ_WIDTH 3
`define WG_IRQ_EXPIRE_BIT 0
`define WG_IRQ_SUPPLY_FAIL_BIT 1
`define WG_IRQ_RESET_END_BIT 2
`define WG_IRQ_MASK_RST 3'h0

`endif

// ==== rtl/wg_pkg.sv ====
package wg_pkg;

  typedef enum logic [1:0] {
    WG_POWER_HOLD,
    WG_STRETCH,
    WG_RUN
  } wg_state_e;

  typedef struct packed {
    logic supply_ok;
    logic backup_ok;
    logic kick;
    logic kick_float;
    logic src_sel;
    logic tb_in;
    logic mem_sel_n;
  } wg_pins_s;

  typedef logic [14:0] wg_count_t;

  typedef struct packed {
    wg_count_t normal;
    wg_count_t long_to;
    wg_count_t rst;
  } wg_limits_s;

endpackage

// ==== rtl/wg_supervisor.sv ====
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "wg_params.svh"
module wg_supervisor #(
  parameter int OSC_DIV = `WG_OSC_DIV,
  parameter bit LONG_RESET = 1'b0,
  parameter bit FIXED_TIMING = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator and pin inputs
  input wire logic supply_valid,
  input wire logic backup_ok,
  input wire logic watchdog_kick_in,
  input wire logic kick_floating,
  input wire logic timebase_source_select,
  input wire logic timebase_input,
  input wire logic mem_select_in_n,
  // Supervisory outputs
  output logic reset_out_n,
  output logic reset_out,
  output logic watchdog_expired_n,
  output logic mem_select_out_n,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Elaboration checks
  generate
    if (OSC_DIV < 2) begin : g_bad_div
      $error("wg_supervisor needs OSC_DIV of at least 2");
    end
  endgenerate

  // ==========================================================
  // Timing limits in timebase ticks
  localparam wg_pkg::wg_count_t INT_LONG = 15'(`WG_MS_TO_TICKS(`WG_T_WD_LONG_MS));
  localparam wg_pkg::wg_count_t INT_SHORT = 15'(`WG_MS_TO_TICKS(`WG_T_WD_SHORT_MS));
  localparam wg_pkg::wg_count_t INT_RST_STD = 15'(`WG_MS_TO_TICKS(`WG_T_RST_STD_MS));
  localparam wg_pkg::wg_count_t INT_RST_LONG = 15'(`WG_MS_TO_TICKS(`WG_T_RST_LONG_MS));
  localparam wg_pkg::wg_count_t EXT_NORMAL = 15'(`WG_EXT_NORMAL);
  localparam wg_pkg::wg_count_t EXT_LONG = 15'(`WG_EXT_LONG);
  localparam wg_pkg::wg_count_t EXT_RST_STD = 15'(`WG_EXT_RST_STD);
  localparam wg_pkg::wg_count_t EXT_RST_LONG = 15'(`WG_EXT_RST_LONG);
  localparam int IW = `WG_IRQ_WIDTH;

  // ==========================================================
  // Declarations
  wg_pkg::wg_pins_s pin_raw;
  wg_pkg::wg_pins_s pin_s;
  wg_pkg::wg_limits_s lim;
  wg_pkg::wg_state_e state_q;
  wg_pkg::wg_state_e state_d;
  wg_pkg::wg_count_t rst_cnt_q;
  wg_pkg::wg_count_t rst_cnt_d;
  wg_pkg::wg_count_t wd_cnt_q;
  wg_pkg::wg_count_t wd_cnt_d;
  wg_pkg::wg_count_t wd_limit;
  logic tick;
  logic ext_mode;
  logic slow_normal;
  logic supply_fail;
  logic kick_prev_q;
  logic kick_edge;
  logic wd_active;
  logic wd_expire;
  logic rst_done;
  logic long_q;
  logic long_d;
  logic reset_n_q;
  logic expired_n_q;
  logic expired_n_d;
  logic mem_sel_n_q;
  logic [IW-1:0] irq_stat_q;
  logic [IW-1:0] irq_stat_d;
  logic [IW-1:0] irq_mask_q;
  logic [IW-1:0] irq_event;
  logic [IW-1:0] irq_clear;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic [31:0] state_word;
  logic apb_setup;
  logic apb_access;
  logic apb_write;
  logic hit_state;
  logic hit_stat;
  logic hit_mask;
  logic hit_any;

  // ==========================================================
  // Input synchronisers
  assign pin_raw.supply_ok = supply_valid;
  assign pin_raw.backup_ok = backup_ok;
  assign pin_raw.kick = watchdog_kick_in;
  assign pin_raw.kick_float = kick_floating;
  assign pin_raw.src_sel = timebase_source_select;
  assign pin_raw.tb_in = timebase_input;
  assign pin_raw.mem_sel_n = mem_select_in_n;

  // Supply starts invalid and memory select idle until pins settle
  wg_sync #(
    .WIDTH($bits(wg_pkg::wg_pins_s)),
    .RST_VAL(7'h0D)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(pin_raw),
    .q(pin_s)
  );

  // ==========================================================
  // Timebase
  // Fixed-timing parts ignore the select and always run internally
  assign ext_mode = ~pin_s.src_sel & ~FIXED_TIMING;

  wg_timebase #(
    .OSC_DIV(OSC_DIV)
  ) u_timebase (
    .clk(clk),
    .sys_rst(sys_rst),
    .ext_mode(ext_mode),
    .ext_level(pin_s.tb_in),
    .tick(tick)
  );

  // ==========================================================
  // Timeout and reset period selection
  assign slow_normal = FIXED_TIMING | pin_s.tb_in;
  assign lim.normal = ext_mode ? EXT_NORMAL :
                      (slow_normal ? INT_LONG : INT_SHORT);
  assign lim.long_to = ext_mode ? EXT_LONG : INT_LONG;
  assign lim.rst = ext_mode ? (LONG_RESET ? EXT_RST_LONG : EXT_RST_STD) :
                   (LONG_RESET ? INT_RST_LONG : INT_RST_STD);
  assign wd_limit = long_q ? lim.long_to : lim.normal;

  // ==========================================================
  // Event decode
  assign supply_fail = ~pin_s.supply_ok;
  assign kick_edge = pin_s.kick ^ kick_prev_q;
  assign wd_active = (state_q == wg_pkg::WG_RUN) & ~pin_s.kick_float;
  // A kick in the expiry cycle wins; >= covers a limit that shrinks mid-count
  assign wd_expire = wd_active & tick & ~kick_edge &
                     (wd_cnt_q >= wd_limit - 15'h0001);
  assign rst_done = (state_q == wg_pkg::WG_STRETCH) & tick &
                    (rst_cnt_q >= lim.rst - 15'h0001);

  // ==========================================================
  // Supervisor state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      wg_pkg::WG_POWER_HOLD: begin
        if (pin_s.supply_ok) begin
          state_d = wg_pkg::WG_STRETCH;
        end
      end
      wg_pkg::WG_STRETCH: begin
        if (supply_fail) begin
          state_d = wg_pkg::WG_POWER_HOLD;
        end else if (rst_done) begin
          state_d = wg_pkg::WG_RUN;
        end
      end
      wg_pkg::WG_RUN: begin
        if (supply_fail) begin
          state_d = wg_pkg::WG_POWER_HOLD;
        end else if (wd_expire) begin
          state_d = wg_pkg::WG_STRETCH;
        end
      end
    endcase
  end

  // ==========================================================
  // Counters and watchdog flags
  always_comb begin
    rst_cnt_d = rst_cnt_q;
    if (state_q != wg_pkg::WG_STRETCH) begin
      rst_cnt_d = '0;
    end else if (tick) begin
      rst_cnt_d = rst_cnt_q + 15'h0001;
    end
  end

  // Count is zero on entry to run, so each reset restarts the watchdog
  always_comb begin
    wd_cnt_d = wd_cnt_q;
    if (state_q != wg_pkg::WG_RUN || kick_edge || pin_s.kick_float) begin
      wd_cnt_d = '0;
    end else if (tick) begin
      wd_cnt_d = wd_cnt_q + 15'h0001;
    end
  end

  // Kicks during reset do not shorten the first timeout
  always_comb begin
    long_d = long_q;
    if (state_q != wg_pkg::WG_RUN) begin
      long_d = 1'b1;
    end else if (kick_edge) begin
      long_d = 1'b0;
    end
  end

  always_comb begin
    expired_n_d = expired_n_q;
    if (supply_fail || pin_s.kick_float) begin
      expired_n_d = 1'b1;
    end else if (kick_edge) begin
      expired_n_d = 1'b1;
    end else if (wd_expire) begin
      expired_n_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= wg_pkg::WG_POWER_HOLD;
      rst_cnt_q <= '0;
      wd_cnt_q <= '0;
      long_q <= 1'b1;
      kick_prev_q <= 1'b0;
      expired_n_q <= 1'b1;
      reset_n_q <= 1'b0;
      mem_sel_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      rst_cnt_q <= rst_cnt_d;
      wd_cnt_q <= wd_cnt_d;
      long_q <= long_d;
      kick_prev_q <= pin_s.kick;
      expired_n_q <= expired_n_d;
      reset_n_q <= (state_d == wg_pkg::WG_RUN);
      mem_sel_n_q <= pin_s.mem_sel_n | supply_fail | ~pin_s.backup_ok;
    end
  end

  // ==========================================================
  // Supervisory outputs
  // Gated select costs five cycles of sync and register; fine for a guard
  assign reset_out_n = reset_n_q;
  assign reset_out = ~reset_n_q;
  assign watchdog_expired_n = expired_n_q;
  assign mem_select_out_n = mem_sel_n_q;

  // ==========================================================
  // APB decode
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign apb_write = apb_access & pwrite;
  assign hit_state = (paddr == `WG_REG_STATE);
  assign hit_stat = (paddr == `WG_REG_IRQ_STATUS);
  assign hit_mask = (paddr == `WG_REG_IRQ_MASK);
  assign hit_any = hit_state | hit_stat | hit_mask;
  assign pready = 1'b1;
  assign pslverr = apb_access & ~hit_any;

  // ==========================================================
  // Interrupt status
  assign irq_event[`WG_IRQ_EXPIRE_BIT] = wd_expire;
  assign irq_event[`WG_IRQ_SUPPLY_FAIL_BIT] = (state_q != wg_pkg::WG_POWER_HOLD) &
                                               (state_d == wg_pkg::WG_POWER_HOLD);
  assign irq_event[`WG_IRQ_RESET_END_BIT] = rst_done & ~supply_fail;
  assign irq_clear = (apb_write && hit_stat) ? pwdata[IW-1:0] : '0;
  // New events win over a same-cycle clear
  assign irq_stat_d = (irq_stat_q & ~irq_clear) | irq_event;
  assign irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_q <= '0;
      irq_mask_q <= `WG_IRQ_MASK_RST;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (apb_write && hit_mask) begin
        irq_mask_q <= pwdata[IW-1:0];
      end
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    state_word = '0;
    state_word[`WG_ST_RESET_N_BIT] = reset_n_q;
    state_word[`WG_ST_EXPIRED_N_BIT] = expired_n_q;
    state_word[`WG_ST_SUPPLY_OK_BIT] = pin_s.supply_ok;
    state_word[`WG_ST_BACKUP_OK_BIT] = pin_s.backup_ok;
    state_word[`WG_ST_LONG_TO_BIT] = long_q;
    state_word[`WG_ST_EXT_MODE_BIT] = ext_mode;
    state_word[`WG_ST_KICK_FLOAT_BIT] = pin_s.kick_float;
  end

  assign rd_mux = hit_state ? state_word :
                  hit_stat ? {{(32-IW){1'b0}}, irq_stat_q} :
                  hit_mask ? {{(32-IW){1'b0}}, irq_mask_q} : 32'h0000_0000;

  // Captured in setup so read data comes from a flop in the access phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  assign prdata = prdata_q;

endmodule // wg_supervisor

// ==== rtl/wg_sync.sv ====
`timescale 1ns/1ps
module wg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Asynchronous levels in, settled levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  generate
    if (WIDTH < 1) begin : g_bad
      $error("wg_sync needs WIDTH of at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // A change counts only once the second and third stages agree
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          s1_q[i] <= RST_VAL[i];
          s2_q[i] <= RST_VAL[i];
          s3_q[i] <= RST_VAL[i];
          q[i] <= RST_VAL[i];
        end else begin
          s1_q[i] <= d[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

endmodule // wg_sync

// ==== rtl/wg_timebase.sv ====
`timescale 1ns/1ps
module wg_timebase #(
  parameter int OSC_DIV = 24414
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Source choice and settled external clock level
  input wire logic ext_mode,
  input wire logic ext_level,
  // One-cycle tick per timebase period
  output logic tick
);

  localparam int DW = $clog2(OSC_DIV);

  generate
    if (OSC_DIV < 2) begin : g_bad
      $error("wg_timebase needs OSC_DIV of at least 2");
    end
  endgenerate

  logic [DW-1:0] div_q;
  logic ext_prev_q;
  logic div_wrap;
  logic ext_rise;

  assign div_wrap = (div_q == DW'(OSC_DIV - 1));
  assign ext_rise = ext_level & ~ext_prev_q;
  // Internal divider stands still in external mode to save toggling
  assign tick = ext_mode ? ext_rise : div_wrap;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= '0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_level;
      if (ext_mode || div_wrap) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + DW'(1);
      end
    end
  end

endmodule // wg_timebase

// ==== tb/wg_host_model.sv ====
`timescale 1ns/1ps
module wg_host_model (
  // Clock
  input wire logic clk,
  // Kick control
  input wire logic run,
  input wire logic [15:0] gap,
  // Kick line
  output logic kick
);
  logic [15:0] cnt_q;
  initial begin
    kick = 1'b0;
    cnt_q = 16'h0000;
  end
  // Line untouched until init is over, then toggled every gap+1 cycles
  always @(posedge clk) begin
    if (!run) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q >= gap) begin
      cnt_q <= 16'h0000;
      kick <= ~kick;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule // wg_host_model

// ==== tb/wg_supervisor_sva.sv ====
`timescale 1ns/1ps
`include "wg_params.svh"
module wg_supervisor_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  // Pins in
  input wire logic supply_valid,
  input wire logic backup_ok,
  input wire logic watchdog_kick_in,
  input wire logic kick_floating,
  input wire logic mem_select_in_n,
  // Pins out
  input wire logic reset_out_n,
  input wire logic reset_out,
  input wire logic watchdog_expired_n,
  input wire logic mem_select_out_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Sequences
  // Eight cycles covers the four-flop synchroniser lag
  sequence supply_low_s;
    (!supply_valid) [*8];
  endsequence
  sequence kick_quiet_s;
    ($stable(watchdog_kick_in) && supply_valid && !kick_floating) [*8];
  endsequence
  // ==========
  // Properties
  rst_low_a: assert property (supply_low_s |-> !reset_out_n)
    else $error("reset released on low supply");
  rst_stretch_a: assert property (supply_low_s ##1 supply_valid |-> (!reset_out_n) [*8])
    else $error("reset not stretched");
  rst_compl_a: assert property (reset_out == !reset_out_n)
    else $error("reset pair not complementary");
  exp_reset_a: assert property ($fell(watchdog_expired_n) |-> !reset_out_n && reset_out)
    else $error("expiry without reset");
  exp_float_a: assert property (kick_floating [*8] |-> watchdog_expired_n)
    else $error("expiry while kick floats");
  exp_hold_a: assert property (kick_quiet_s ##0 !watchdog_expired_n |=> !watchdog_expired_n)
    else $error("expiry released without kick");
  exp_supply_a: assert property (supply_low_s |-> watchdog_expired_n)
    else $error("expiry low on low supply");
  mem_pass_a: assert property ((supply_valid && backup_ok && $stable(mem_select_in_n))
    [*8] |-> mem_select_out_n == mem_select_in_n)
    else $error("memory select not passed");
  mem_gate_a: assert property ((!supply_valid || !backup_ok) [*8] |-> mem_select_out_n)
    else $error("memory select not gated");
  bus_err_a: assert property (psel && penable && !(paddr inside {`WG_REG_STATE,
    `WG_REG_IRQ_STATUS, `WG_REG_IRQ_MASK}) |-> pslverr)
    else $error("unmapped access not refused");
endmodule // wg_supervisor_sva

bind wg_supervisor wg_supervisor_sva u_sva (.clk, .sys_rst, .psel, .penable, .paddr, .pslverr,
  .supply_valid, .backup_ok, .watchdog_kick_in, .kick_floating, .mem_select_in_n,
  .reset_out_n, .reset_out, .watchdog_expired_n, .mem_select_out_n);

// ==== tb/wg_supervisor_test.sv ====
`timescale 1ns/1ps
`include "wg_params.svh"
module wg_supervisor_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, reset_out_n, reset_out, watchdog_expired_n, mem_select_out_n, irq;
  logic supply_valid = 1'b0, backup_ok = 1'b0, kick_floating = 1'b0;
  logic timebase_source_select = 1'b0, timebase_input = 1'b0, mem_select_in_n = 1'b1;
  logic watchdog_kick_in, run = 1'b0;
  logic ext_clk_on = 1'b1, fix_reset_n;
  logic [15:0] gap = 16'h0100;
  logic [1:0] div_q = 2'h0;
  logic kick_prev = 1'b0;
  logic [31:0] seed_q = 32'h0000_0056;
  int n_errors = 0, checks_done = 0, since_kick = 0, rst_lows = 0;

  wg_supervisor #(.OSC_DIV(4)) u_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .supply_valid, .backup_ok, .watchdog_kick_in,
    .kick_floating, .timebase_source_select, .timebase_input, .mem_select_in_n,
    .reset_out_n, .reset_out, .watchdog_expired_n, .mem_select_out_n, .irq);
  wg_host_model u_host (.clk, .run, .gap, .kick(watchdog_kick_in));
  // Fixed-timing, long-reset variant on the same pins
  wg_supervisor #(.OSC_DIV(4), .LONG_RESET(1'b1), .FIXED_TIMING(1'b1)) u_fix (.clk, .sys_rst,
    .psel(1'b0), .penable(1'b0), .pwrite(1'b0), .paddr(8'h00), .pwdata(32'h0000_0000),
    .prdata(), .pready(), .pslverr(), .supply_valid, .backup_ok, .watchdog_kick_in,
    .kick_floating, .timebase_source_select, .timebase_input, .mem_select_in_n,
    .reset_out_n(fix_reset_n), .reset_out(), .watchdog_expired_n(), .mem_select_out_n(),
    .irq());

  always #2 clk = ~clk;
  // External timebase: one rising edge every four cycles
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    timebase_input <= ext_clk_on & div_q[1];
    kick_prev <= watchdog_kick_in;
    since_kick <= (kick_prev != watchdog_kick_in) ? 0 : since_kick + 1;
  end
  always @(negedge clk) if (reset_out_n !== 1'b1) rst_lows++;

  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int ticks(input int n);
    return n * 4;
  endfunction
  // Slack for synchroniser lag and tick phase
  function automatic logic near(input int d, input int e);
    return d >= e - 12 && d <= e + 12;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic pick(input int which);
    if (which == 2) return fix_reset_n;
    if (which == 1) return watchdog_expired_n;
    return reset_out_n;
  endfunction
  // A cap that runs out counts as a mismatch
  task automatic wait_for(input int which, input logic val, input int cap, output int d);
    d = 0;
    @(negedge clk);
    while (pick(which) !== val && d < cap) begin
      @(negedge clk);
      d++;
    end
    if (pick(which) !== val) n_errors++;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Waits as long as the slave asks; only the time limit ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #380000;
    n_errors++;
    wrap_up();
  end

  // ==========
  // Tests
  initial begin
    int d, e;
    logic [31:0] rd;
    logic er;
    cyc(8);
    sys_rst <= 1'b0;
    cyc(20);
    @(negedge clk);
    check(reset_out_n, 1'b0, "reset on low supply");
    check(reset_out, 1'b1, "high reset");
    check(watchdog_expired_n, 1'b1, "expiry on low supply");
    check(mem_select_out_n, 1'b1, "memory gated");
    @(posedge clk);
    supply_valid <= 1'b1;
    backup_ok <= 1'b1;
    wait_for(0, 1'b1, 4000, d);
    check(near(d, ticks(`WG_EXT_RST_STD) + 4), 1'b1, "power-up stretch");
    check(fix_reset_n, 1'b0, "fixed part still in reset");
    wait_for(2, 1'b1, 8000, e);
    e = e + d + 1;
    check(near(e, ticks(`WG_MS_TO_TICKS(`WG_T_RST_LONG_MS)) + 4), 1'b1, "long reset");
    $display("test power-up done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      seed_q = xs(seed_q);
      mem_select_in_n <= seed_q[0];
      cyc(8);
      @(negedge clk);
      check(mem_select_out_n, seed_q[0], "memory pass");
    end
    @(posedge clk);
    backup_ok <= 1'b0;
    mem_select_in_n <= 1'b0;
    cyc(8);
    @(negedge clk);
    check(mem_select_out_n, 1'b1, "memory gated on backup");
    @(posedge clk);
    backup_ok <= 1'b1;
    $display("test memory select done");
    seed_q = xs(seed_q);
    gap <= 16'h0200 + {6'h00, seed_q[9:0]};
    run <= 1'b1;
    d = rst_lows;
    cyc(20000);
    check(rst_lows - d, 0, "reset while kicked");
    check(fix_reset_n, 1'b1, "fixed part running");
    apb(1'b0, `WG_REG_STATE, 32'h0000_0000, rd, er);
    check(rd[`WG_ST_LONG_TO_BIT], 1'b0, "normal timeout after kick");
    @(posedge clk);
    run <= 1'b0;
    wait_for(1, 1'b0, 8000, d);
    check(near(since_kick, ticks(`WG_EXT_NORMAL) + 4), 1'b1, "normal timeout");
    check(reset_out_n, 1'b0, "watchdog reset");
    wait_for(0, 1'b1, 4000, d);
    check(near(d, ticks(`WG_EXT_RST_STD)), 1'b1, "watchdog reset width");
    apb(1'b0, `WG_REG_STATE, 32'h0000_0000, rd, er);
    check(rd[`WG_ST_LONG_TO_BIT], 1'b1, "long timeout after reset");
    wait_for(0, 1'b0, 20000, d);
    check(near(d, ticks(`WG_EXT_LONG) - 12), 1'b1, "long timeout");
    check(watchdog_expired_n, 1'b0, "expiry held");
    $display("test watchdog done");
    apb(1'b0, `WG_REG_IRQ_STATUS, 32'h0000_0000, rd, er);
    check(rd[`WG_IRQ_EXPIRE_BIT], 1'b1, "expiry event");
    check(irq, 1'b0, "masked interrupt");
    apb(1'b1, `WG_REG_IRQ_MASK, 32'h0000_0001, rd, er);
    @(negedge clk);
    check(irq, 1'b1, "unmasked interrupt");
    apb(1'b1, `WG_REG_IRQ_STATUS, 32'h0000_0001, rd, er);
    @(negedge clk);
    check(irq, 1'b0, "cleared interrupt");
    apb(1'b0, 8'h0C, 32'h0000_0000, rd, er);
    check(er, 1'b1, "unmapped refused");
    check(pready, 1'b1, "zero wait states");
    $display("test registers done");
    @(posedge clk);
    supply_valid <= 1'b0;
    cyc(8);
    @(negedge clk);
    check(watchdog_expired_n, 1'b1, "expiry forced high");
    check(reset_out_n, 1'b0, "reset on supply drop");
    check(mem_select_out_n, 1'b1, "memory gated on drop");
    @(posedge clk);
    supply_valid <= 1'b1;
    kick_floating <= 1'b1;
    wait_for(0, 1'b1, 4000, d);
    d = rst_lows;
    cyc(18000);
    check(rst_lows - d, 0, "no reset while floating");
    check(watchdog_expired_n, 1'b1, "expiry high while floating");
    $display("test supply and float done");
    // Internal timebase with the timebase input held low picks the short timeout
    @(posedge clk);
    kick_floating <= 1'b0;
    timebase_source_select <= 1'b1;
    ext_clk_on <= 1'b0;
    run <= 1'b1;
    cyc(3000);
    apb(1'b0, `WG_REG_STATE, 32'h0000_0000, rd, er);
    check(rd[`WG_ST_EXT_MODE_BIT], 1'b0, "internal timebase");
    check(rd[`WG_ST_LONG_TO_BIT], 1'b0, "normal timeout after kick");
    @(posedge clk);
    run <= 1'b0;
    wait_for(1, 1'b0, 8000, d);
    e = ticks(`WG_MS_TO_TICKS(`WG_T_WD_SHORT_MS)) + 4;
    check(near(since_kick, e), 1'b1, "internal short timeout");
    $display("test internal timebase done");
    wrap_up();
  end
endmodule // wg_supervisor_test
